// >>> ssr_defines.svh
// constants for the smbus register slave
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

`define SSR_SLAVE_ADDR   7'h2E
`define SSR_BYTE_BITS    4'h8
`define SSR_MAX_WBYTES   2'h2
`define SSR_CLK_NS       40
`define SSR_RRST_NS      10000
`define SSR_HW_TRIP_DEF  8'h64
// idle pin levels: power present, input low, sda high, scl high
`define SSR_SYNC_RST     4'hB

`define SSR_NUM_REGS     12
`define SSR_IDX_CFG      8'h00
`define SSR_IDX_STAT     8'h01
`define SSR_IDX_MASK     8'h02
`define SSR_IDX_LOC_VAL  8'h03
`define SSR_IDX_REM_VAL  8'h04
`define SSR_IDX_LIM0     8'h05
`define SSR_IDX_ANALOG   8'h09
`define SSR_IDX_ALERT    8'h0A
`define SSR_IDX_RFUNC    8'h0B

`define SSR_CFG_INT_EN   1
`define SSR_CFG_GIN_POL  2
`define SSR_RF_RRST      0
`define SSR_RF_ROFF      1
`define SSR_ST_GIN       4
`define SSR_ST_HWTRIP    5

`define SSR_CFG_RST      8'h00
`define SSR_MASK_RST     8'h00
`define SSR_ANALOG_RST   8'h00
`define SSR_LIM_HI_RST   8'h7F
`define SSR_LIM_LO_RST   8'h80
`define SSR_FAN_FULL     8'hFF

`endif

// >>> ssr_host_model.sv
// behavioural smbus host master driving scl and pulling sda
`timescale 1ns/10ps

module ssr_host_model (
    input  wire logic pclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // also serves as repeated start when entered with scl low
    task automatic start_c();
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic stop_c();
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(4);
    endtask

    // sda only moves while scl is low
    task automatic bit_x(input logic b, output logic s);
        sda_pull <= !b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        s = sda_line;
        scl <= 1'b0;
        tick(2);
    endtask

    task automatic byte_x(input logic [7:0] d, input logic ack_in,
                          output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ack_in, ack);
    endtask
endmodule

// >>> ssr_pkg.sv
// types shared by the smbus register slave
package ssr_pkg;
    typedef logic signed [7:0] ssr_temp_t;
    typedef enum logic [2:0] {
        SSR_IDLE, SSR_ADDR, SSR_WACK, SSR_WDATA, SSR_RDATA, SSR_RACK
    } ssr_state_t;
    typedef struct packed {
        logic       en;
        logic [7:0] idx;
        logic [7:0] data;
    } ssr_wr_t;
endpackage

// >>> ssr_smbus_slave.sv
// smbus slave with pointer-addressed register file and apb access
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ssr_defines.svh"

module ssr_smbus_slave #(
    parameter logic [7:0] HW_TRIP = `SSR_HW_TRIP_DEF,
    parameter int         RRST_NS = `SSR_RRST_NS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scl,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire ssr_pkg::ssr_temp_t local_temp,
    input  wire ssr_pkg::ssr_temp_t remote_temp,
    input  wire logic              general_input,
    input  wire logic              main_pwr_n,
    output logic                   int_oe,
    output logic                   over_temp_alert_oe,
    output logic                   rrst_oe,
    output logic                   remote_off,
    output logic [7:0]             fan_speed_out
);
    import ssr_pkg::*;

    localparam int RRST_CYC = (RRST_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS;

    // pin synchronisers: stage 1, stage 2, history
    logic [3:0] s1_ff, s2_ff;
    logic [1:0] q_ff;
    logic       scl_s, sda_s, gin_s, pwr_s;
    logic       scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= `SSR_SYNC_RST;
            s2_ff <= `SSR_SYNC_RST;
            q_ff  <= 2'h3;
        end else begin
            s1_ff <= {main_pwr_n, general_input, sda_in, scl};
            s2_ff <= s1_ff;
            q_ff  <= s2_ff[1:0];
        end
    end

    assign scl_s     = s2_ff[0];
    assign sda_s     = s2_ff[1];
    assign gin_s     = s2_ff[2];
    assign pwr_s     = s2_ff[3];
    assign scl_rise  = scl_s & ~q_ff[0];
    assign scl_fall  = ~scl_s & q_ff[0];
    assign start_det = scl_s & q_ff[0] & q_ff[1] & ~sda_s;
    assign stop_det  = scl_s & q_ff[0] & ~q_ff[1] & sda_s;

    // smbus byte engine
    ssr_state_t st_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff, tx_ff, ptr_ff;
    logic       sda_oe_ff, dir_ff;
    logic [1:0] nbyte_ff;
    logic       byte_done, addr_hit;
    logic [7:0] rd_ptr;

    assign byte_done = scl_fall && (cnt_ff == `SSR_BYTE_BITS);
    assign addr_hit  = (sh_ff[7:1] == `SSR_SLAVE_ADDR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff     <= SSR_IDLE;
            cnt_ff    <= 4'h0;
            sh_ff     <= 8'h00;
            tx_ff     <= 8'h00;
            sda_oe_ff <= 1'b0;
            dir_ff    <= 1'b0;
            nbyte_ff  <= 2'h0;
        end else if (stop_det) begin
            st_ff     <= SSR_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (start_det) begin
            st_ff     <= SSR_ADDR;
            cnt_ff    <= 4'h0;
            sda_oe_ff <= 1'b0;
        end else begin
            case (st_ff)
                SSR_ADDR, SSR_WDATA: begin
                    if (scl_rise) begin
                        sh_ff  <= {sh_ff[6:0], sda_s};
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        if (st_ff == SSR_ADDR) begin
                            if (addr_hit) begin
                                sda_oe_ff <= 1'b1;
                                dir_ff    <= sh_ff[0];
                                nbyte_ff  <= 2'h0;
                                st_ff     <= SSR_WACK;
                            end else begin
                                st_ff <= SSR_IDLE;
                            end
                        end else if (nbyte_ff < `SSR_MAX_WBYTES) begin
                            sda_oe_ff <= 1'b1;
                            nbyte_ff  <= nbyte_ff + 2'h1;
                            st_ff     <= SSR_WACK;
                        end else begin
                            st_ff <= SSR_IDLE;
                        end
                    end
                end
                SSR_WACK: begin
                    if (scl_fall) begin
                        cnt_ff <= 4'h0;
                        if (dir_ff) begin
                            tx_ff     <= rd_ptr;
                            sda_oe_ff <= ~rd_ptr[7];
                            st_ff     <= SSR_RDATA;
                        end else begin
                            sda_oe_ff <= 1'b0;
                            st_ff     <= SSR_WDATA;
                        end
                    end
                end
                SSR_RDATA: begin
                    if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        sda_oe_ff <= 1'b0;
                        st_ff     <= SSR_RACK;
                    end else if (scl_fall) begin
                        tx_ff     <= {tx_ff[6:0], 1'b0};
                        sda_oe_ff <= ~tx_ff[6];
                    end
                end
                SSR_RACK: begin
                    if (scl_rise) begin
                        st_ff <= SSR_IDLE;
                    end
                end
                default: begin
                    st_ff <= SSR_IDLE;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_ff;

    // pointer survives aborts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= 8'h00;
        end else if (st_ff == SSR_WDATA && byte_done && nbyte_ff == 2'h0) begin
            ptr_ff <= sh_ff;
        end
    end

    // shared write port, smbus first
    ssr_wr_t    wr;
    logic       smb_wr, apb_acc, apb_bad;
    logic [7:0] apb_idx;

    assign smb_wr  = (st_ff == SSR_WDATA) && byte_done && (nbyte_ff == 2'h1);
    assign apb_idx = paddr[9:2];
    assign apb_bad = (paddr[11:10] != 2'h0) || (paddr[1:0] != 2'h0) ||
                     (apb_idx >= 8'(`SSR_NUM_REGS));
    assign pready  = ~smb_wr;
    assign apb_acc = psel & penable & pready;
    assign pslverr = apb_acc & apb_bad;

    always_comb begin
        wr = '0;
        if (smb_wr) begin
            wr.en   = 1'b1;
            wr.idx  = ptr_ff;
            wr.data = sh_ff;
        end else if (apb_acc && pwrite && !apb_bad) begin
            wr.en   = 1'b1;
            wr.idx  = apb_idx;
            wr.data = pwdata[7:0];
        end
    end

    // register file
    logic [7:0] cfg_ff, stat_ff, mask_ff, analog_ff;
    logic [7:0] lim_ff [0:3];
    logic [3:0] lim_ev;
    logic       roff_ff, rrst_act;
    logic [8:0] rrst_cnt_ff;
    logic       hw_trip, alert, gin_act;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff    <= `SSR_CFG_RST;
            mask_ff   <= `SSR_MASK_RST;
            analog_ff <= `SSR_ANALOG_RST;
        end else if (wr.en) begin
            if (wr.idx == `SSR_IDX_CFG) begin
                cfg_ff <= wr.data;
            end else if (wr.idx == `SSR_IDX_MASK) begin
                mask_ff <= wr.data;
            end else if (wr.idx == `SSR_IDX_ANALOG) begin
                analog_ff <= wr.data;
            end
        end
    end

    // limits: even entries high, odd low; local then remote
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lim
            localparam logic [7:0] LIM_RST =
                (gi % 2 == 0) ? `SSR_LIM_HI_RST : `SSR_LIM_LO_RST;
            ssr_temp_t t;
            assign t = (gi < 2) ? local_temp : remote_temp;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lim_ff[gi] <= LIM_RST;
                end else if (wr.en && wr.idx == `SSR_IDX_LIM0 + 8'(gi)) begin
                    lim_ff[gi] <= wr.data;
                end
            end
            assign lim_ev[gi] = (gi % 2 == 0) ? (t > $signed(lim_ff[gi]))
                                              : (t < $signed(lim_ff[gi]));
        end
    endgenerate

    assign hw_trip = remote_temp > $signed(HW_TRIP);
    assign alert   = hw_trip | lim_ev[2];
    assign gin_act = gin_s ^ cfg_ff[`SSR_CFG_GIN_POL];

    // sticky status, write one to clear, set wins
    logic [7:0] ev, clr;
    assign ev = {2'b00, hw_trip, gin_act, lim_ev};
    assign clr = (wr.en && wr.idx == `SSR_IDX_STAT) ? wr.data : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= 8'h00;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev;
        end
    end

    // remote function: self-clearing reset pulse, latched off
    assign rrst_act = (rrst_cnt_ff != 9'h000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rrst_cnt_ff <= 9'h000;
        end else if (wr.en && wr.idx == `SSR_IDX_RFUNC &&
                     wr.data[`SSR_RF_RRST]) begin
            rrst_cnt_ff <= 9'(RRST_CYC);
        end else if (rrst_act) begin
            rrst_cnt_ff <= rrst_cnt_ff - 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roff_ff <= 1'b0;
        end else if (!pwr_s) begin
            roff_ff <= 1'b0;
        end else if (wr.en && wr.idx == `SSR_IDX_RFUNC &&
                     wr.data[`SSR_RF_ROFF]) begin
            roff_ff <= 1'b1;
        end
    end

    // pin outputs: int, alert and fan registered here, rrst_oe decoded from the reset counter
    logic int_ff, alert_ff;
    logic [7:0] fan_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ff   <= 1'b0;
            alert_ff <= 1'b0;
            fan_ff   <= `SSR_ANALOG_RST;
        end else begin
            int_ff   <= cfg_ff[`SSR_CFG_INT_EN] &
                        (|(stat_ff & ~mask_ff));
            alert_ff <= alert;
            if (!pwr_s) begin
                fan_ff <= `SSR_ANALOG_RST;
            end else if (alert) begin
                fan_ff <= `SSR_FAN_FULL;
            end else begin
                fan_ff <= analog_ff;
            end
        end
    end

    assign int_oe             = int_ff;
    assign over_temp_alert_oe = alert_ff;
    assign rrst_oe            = rrst_act;
    assign remote_off         = roff_ff;
    assign fan_speed_out      = fan_ff;

    // read view
    logic [7:0] rview [0:`SSR_NUM_REGS-1];

    always_comb begin
        rview[0]  = cfg_ff;
        rview[1]  = stat_ff;
        rview[2]  = mask_ff;
        rview[3]  = local_temp;
        rview[4]  = remote_temp;
        rview[5]  = lim_ff[0];
        rview[6]  = lim_ff[1];
        rview[7]  = lim_ff[2];
        rview[8]  = lim_ff[3];
        rview[9]  = analog_ff;
        rview[10] = {6'h00, gin_s, alert};
        rview[11] = {6'h00, roff_ff, rrst_act};
    end

    assign rd_ptr = (ptr_ff < 8'(`SSR_NUM_REGS)) ? rview[ptr_ff[3:0]] : 8'h00;

    // apb read data captured in setup phase
    logic [31:0] prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_ff <= apb_bad ? 32'h0000_0000
                                 : {24'h000000, rview[apb_idx[3:0]]};
        end
    end

    assign prdata = prdata_ff;

    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ack_own: assert property (
        st_ff == SSR_ADDR && byte_done && addr_hit |=>
            sda_oe_ff && st_ff == SSR_WACK)
        else $error("own address not acknowledged");

    chk_ignore_other: assert property (
        st_ff == SSR_ADDR && byte_done && !addr_hit |=>
            !sda_oe_ff && st_ff == SSR_IDLE)
        else $error("foreign address acknowledged");

    chk_ptr_load: assert property (
        st_ff == SSR_WDATA && byte_done && nbyte_ff == 2'h0 && !stop_det
            |=> ptr_ff == $past(sh_ff))
        else $error("pointer not loaded");

    chk_data_store: assert property (
        smb_wr && ptr_ff == `SSR_IDX_ANALOG |=>
            analog_ff == $past(sh_ff))
        else $error("second byte not stored");

    chk_stop_abort: assert property (
        stop_det |=> st_ff == SSR_IDLE && !sda_oe_ff && $stable(ptr_ff))
        else $error("stop did not abort");

    chk_int_gate: assert property (
        !cfg_ff[`SSR_CFG_INT_EN] |=> !int_oe)
        else $error("interrupt driven while disabled");

    chk_fan_force: assert property (
        alert && pwr_s |=> fan_speed_out == `SSR_FAN_FULL)
        else $error("fan not forced to full");

    chk_roff_hold: assert property (
        roff_ff && pwr_s |=> roff_ff)
        else $error("remote off dropped early");

    chk_stat_sticky: assert property (
        stat_ff[0] && !clr[0] |=> stat_ff[0])
        else $error("status bit lost");

    chk_sda_change: assert property (
        $changed(sda_oe_ff) |-> $past(scl_fall || stop_det || start_det))
        else $error("sda changed outside low phase");

    chk_rrst_width: assert property (
        $rose(rrst_act) |-> rrst_act [*8])
        else $error("remote reset pulse too short");
endmodule

// >>> test_smbus_slave_register_access.sv
// self-checking bench for the smbus register slave
`timescale 1ns/10ps
`include "ssr_defines.svh"

module test_smbus_slave_register_access;
    import ssr_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, scl, sda_line, host_pull;
    logic              sda_out, sda_oe, general_input, main_pwr_n;
    logic              int_oe, over_temp_alert_oe, rrst_oe, remote_off;
    ssr_temp_t         local_temp, remote_temp;
    logic [7:0]        fan_speed_out;
    int                n_mismatch, checked, seed;
    int                regs_m[12];
    logic [31:0]       q;
    logic              e, k;
    logic [7:0]        d;

    assign sda_line = !host_pull & (sda_oe ? sda_out : 1'b1);

    ssr_smbus_slave #(.RRST_NS(400)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .local_temp(local_temp),
        .remote_temp(remote_temp), .general_input(general_input),
        .main_pwr_n(main_pwr_n), .int_oe(int_oe),
        .over_temp_alert_oe(over_temp_alert_oe), .rrst_oe(rrst_oe),
        .remote_off(remote_off), .fan_speed_out(fan_speed_out));

    ssr_host_model host (.pclk(pclk), .sda_line(sda_line), .scl(scl),
        .sda_pull(host_pull));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] ex, got);
        checked++;
        if (got !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && idx < 12 && !(idx inside {3, 4, 10})) regs_m[idx] = wd;
    endtask

    task automatic smb_wr(input logic [6:0] a, input logic [7:0] p, wd);
        logic [7:0] r;
        logic k2;
        host.start_c();
        host.byte_x({a, 1'b0}, 1'b1, r, k);
        if (!k) host.byte_x(p, 1'b1, r, k2);
        if (!k) host.byte_x(wd, 1'b1, r, k2);
        host.stop_c();
        if (!k && p < 12) regs_m[p] = wd;
    endtask

    task automatic smb_rd(input logic [7:0] p);
        logic k2;
        host.start_c();
        host.byte_x({`SSR_SLAVE_ADDR, 1'b0}, 1'b1, d, k);
        host.byte_x(p, 1'b1, d, k2);
        host.start_c();
        host.byte_x({`SSR_SLAVE_ADDR, 1'b1}, 1'b1, d, k2);
        host.byte_x(8'hFF, 1'b1, d, k2);
        host.stop_c();
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        static int rst_idx[7] = '{0, 2, 5, 6, 7, 8, 9};
        static int rst_val[7] = '{0, 0, 8'h7F, 8'h80, 8'h7F, 8'h80, 0};
        n_mismatch = 0;
        checked = 0;
        seed = 32'hEEA67924;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        general_input = 1'b0;
        main_pwr_n = 1'b1;
        local_temp = 8'h10;
        remote_temp = 8'h00;
        foreach (regs_m[i]) regs_m[i] = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        foreach (rst_idx[i]) begin
            apb(1'b0, rst_idx[i], 8'h00);
            chk("reset value", rst_val[i], q);
        end
        chk("fan at reset", 32'h0, fan_speed_out);
        chk("int at reset", 32'h0, int_oe);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            local_temp <= $random(seed) & 8'h3F;
            smb_wr(`SSR_SLAVE_ADDR, `SSR_IDX_ANALOG, d);
            chk("write ack", 32'h0, k);
            chk("fan code", regs_m[9], fan_speed_out);
            apb(1'b0, `SSR_IDX_ANALOG, 8'h00);
            chk("analog reg", regs_m[9], q);
            apb(1'b1, `SSR_IDX_LIM0, $random(seed));
            smb_rd(`SSR_IDX_LIM0);
            chk("read data", regs_m[5], d);
            smb_rd(`SSR_IDX_LOC_VAL);
            chk("local value", {24'h0, local_temp}, d);
        end
        smb_wr(7'h2F, `SSR_IDX_ANALOG, 8'h5A);
        chk("foreign nack", 32'h1, k);
        chk("fan unchanged", regs_m[9], fan_speed_out);
        apb(1'b1, `SSR_IDX_LOC_VAL, 8'hA5);
        apb(1'b0, `SSR_IDX_LOC_VAL, 8'h00);
        chk("read only", {24'h0, local_temp}, q);
        apb(1'b0, 8'h0C, 8'h00);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, q);
        smb_wr(`SSR_SLAVE_ADDR, `SSR_IDX_RFUNC, 8'h02);
        chk("remote off", 32'h1, remote_off);
        repeat (20) @(posedge pclk);
        chk("remote off held", 32'h1, remote_off);
        main_pwr_n <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("power loss off", 32'h0, remote_off);
        chk("power loss fan", 32'h0, fan_speed_out);
        main_pwr_n <= 1'b1;
        repeat (8) @(posedge pclk);
        remote_temp <= 8'h65;
        repeat (8) @(posedge pclk);
        chk("trip fan", `SSR_FAN_FULL, fan_speed_out);
        chk("trip alert", 32'h1, over_temp_alert_oe);
        remote_temp <= 8'h64;
        repeat (8) @(posedge pclk);
        chk("trip clear", regs_m[9], fan_speed_out);
        general_input <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, `SSR_IDX_ALERT, 8'h00);
        chk("alert status", 32'h2, q);
        apb(1'b1, `SSR_IDX_CFG, 8'h02);
        repeat (2) @(posedge pclk);
        chk("int raised", 32'h1, int_oe);
        apb(1'b1, `SSR_IDX_MASK, 8'hFF);
        repeat (2) @(posedge pclk);
        chk("int masked", 32'h0, int_oe);
        apb(1'b1, `SSR_IDX_RFUNC, 8'h01);
        @(posedge pclk);
        chk("remote reset", 32'h1, rrst_oe);
        repeat (12) @(posedge pclk);
        chk("remote reset end", 32'h0, rrst_oe);
        end_of_test();
    end
endmodule
